// File: dv/testbench.sv
`include "wes_map.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import wes_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wes_addr_t reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wes_byte_t reg_wdata = 8'h00;
    wes_byte_t reg_rdata;
    logic [23:0] src = 24'h000000; // Source levels in status bit order
    wes_byte_t en_misc = 8'h00;
    wes_byte_t en_grp1 = 8'h00;
    wes_byte_t en_grp2 = 8'h00;
    logic wake_request_n;
    int wake_count;
    int miscompares = 0;
    int n_checks = 0;

    // Free-running 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    wes_wake_status DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ring_indicator_first(src[2]), .ring_indicator_second(src[1]),
        .keyboard_wake(src[3]), .mouse_wake(src[4]), .specific_key_wake(src[5]),
        .fan_speed_input_first(src[6]), .fan_speed_input_second(src[7]),
        .gen_pins_10_17(src[15:8]), .gen_pins_20_22(src[18:16]),
        .grouped_device_interrupt_status(src[19]), .gen_pins_24_27(src[23:20]),
        .src_enable_misc(en_misc), .src_enable_grp1(en_grp1), .src_enable_grp2(en_grp2),
        .wake_request_n(wake_request_n));

    wes_host_model host (.clk(clk), .rst_n(rst_n), .wake_request_n(wake_request_n),
        .wake_count(wake_count));

    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input wes_byte_t seen, input wes_byte_t exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe; data and address held with it
    task automatic wr(input wes_addr_t a, input wes_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data lands on the edge that takes the strobe
    task automatic rd_chk(input string what, input wes_addr_t a, input wes_byte_t e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, reg_rdata, e);
    endtask

    // Bounded wait on the request level; a hang ends the run
    task automatic wait_req(input logic lvl);
        for (int k = 0; k < 20 && wake_request_n !== lvl; k++) begin
            @(posedge clk);
            #1;
        end
        if (wake_request_n !== lvl) begin
            miscompares++;
            $display("Error wake_request_n expected %b seen %b", lvl, wake_request_n);
            close_out();
        end
    endtask

    initial begin
        wes_addr_t a;
        wes_byte_t m;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd_chk("reset value", i[7:0], 8'h00);
        chk("request idle", {7'h00, wake_request_n}, 8'h01);
        $display("Test reset_values done");
        wr(`WES_OFS_ENABLE, 8'hff);
        wr(`WES_OFS_RSVD_ONE, 8'hff);
        wr(`WES_OFS_RSVD_THREE, 8'hff);
        rd_chk("global enable", `WES_OFS_ENABLE, 8'h01);
        rd_chk("reserved one", `WES_OFS_RSVD_ONE, 8'h00);
        rd_chk("reserved three", `WES_OFS_RSVD_THREE, 8'h00);
        $display("Test reserved done");
        // Every source with its own enable off: status only, no request
        for (int i = 1; i < 24; i++) begin
            a = 8'(`WES_OFS_STS_MISC + i / 8);
            m = 8'(1 << (i % 8));
            @(posedge clk);
            src[i] <= 1'b1;
            repeat (6) @(posedge clk);
            rd_chk("source status", a, m);
            rd_chk("flag disabled source", `WES_OFS_FLAG, 8'h00);
            chk("request disabled source", {7'h00, wake_request_n}, 8'h01);
            wr(a, ~m);
            rd_chk("status after zero", a, m);
            wr(a, m);
            rd_chk("status after one", a, 8'h00);
            @(posedge clk);
            src[i] <= 1'b0;
        end
        $display("Test source_map done");
        @(posedge clk);
        en_misc <= 8'h08;
        src[3] <= 1'b1;
        wait_req(1'b0);
        rd_chk("flag on wake", `WES_OFS_FLAG, 8'h01);
        repeat (4) @(posedge clk);
        chk("request held", {7'h00, wake_request_n}, 8'h00);
        wr(`WES_OFS_STS_MISC, 8'h08);
        wait_req(1'b1);
        wr(`WES_OFS_FLAG, 8'h00);
        rd_chk("flag after zero", `WES_OFS_FLAG, 8'h01);
        wr(`WES_OFS_FLAG, 8'h01);
        rd_chk("flag after one", `WES_OFS_FLAG, 8'h00);
        @(posedge clk);
        src[3] <= 1'b0;
        $display("Test enabled_wake done");
        // Global enable off: flag still records, pin stays quiet until enabled
        wr(`WES_OFS_ENABLE, 8'h00);
        @(posedge clk);
        src[3] <= 1'b1;
        repeat (6) @(posedge clk);
        rd_chk("flag gated", `WES_OFS_FLAG, 8'h01);
        chk("request gated", {7'h00, wake_request_n}, 8'h01);
        wr(`WES_OFS_ENABLE, 8'h01);
        wait_req(1'b0);
        wr(`WES_OFS_FLAG, 8'h01);
        wait_req(1'b1);
        rd_chk("status kept", `WES_OFS_STS_MISC, 8'h08);
        chk("host wake count", 8'(wake_count), 8'h02);
        $display("Test global_gate done");
        // Group enables: request stands while any enabled source is pending
        wr(`WES_OFS_STS_MISC, 8'h08);
        @(posedge clk);
        en_grp1 <= 8'h01;
        en_grp2 <= 8'h08;
        src[8] <= 1'b1;
        src[19] <= 1'b1;
        wait_req(1'b0);
        wr(`WES_OFS_STS_GRP1, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk("request second source", {7'h00, wake_request_n}, 8'h00);
        wr(`WES_OFS_STS_GRP2, 8'h08);
        wait_req(1'b1);
        rd_chk("flag group", `WES_OFS_FLAG, 8'h01);
        chk("host wake count group", 8'(wake_count), 8'h03);
        $display("Test group_wake done");
        close_out();
    end
endmodule // testbench

`default_nettype wire

// File: dv/wes_host_model.sv
`default_nettype none

module wes_host_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wake_request_n,
    output var int wake_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic seen_low;

    // Count each new low level, as a chipset latches one wake per assertion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_low <= 1'b0;
            wake_count <= 0;
        end else begin
            seen_low <= !wake_request_n;
            if (!wake_request_n && !seen_low) begin
                wake_count <= wake_count + 1;
            end
        end
    end
endmodule // wes_host_model

`default_nettype wire

// File: hw/wes_edge_detect.sv
`default_nettype none

module wes_edge_detect #(
    parameter int W = 1,
    parameter bit SYNC = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] level_in,
    output logic [W-1:0] rise_pulse
);
    logic [W-1:0] stage_reg;
    logic [W-1:0] prev_reg;

    // Pins pass two flops; same-clock logic passes one flop
    generate
        if (SYNC) begin : g_sync
            logic [W-1:0] meta_reg;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg <= '0;
                    stage_reg <= '0;
                end else begin
                    meta_reg <= level_in;
                    stage_reg <= meta_reg;
                end
            end
        end else begin : g_direct
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_reg <= '0;
                end else begin
                    stage_reg <= level_in;
                end
            end
        end
    endgenerate

    // Previous settled level for the rising-edge compare
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= stage_reg;
        end
    end

    // One-cycle pulse per low-to-high change of the settled level
    assign rise_pulse = stage_reg & ~prev_reg;
endmodule // wes_edge_detect

`default_nettype wire

// File: hw/wes_wake_status.sv
`include "wes_map.svh"
`default_nettype none

module wes_wake_status (
    input wire logic clk,
    input wire logic rst_n,
    input wire wes_pkg::wes_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire wes_pkg::wes_byte_t reg_wdata,
    output wes_pkg::wes_byte_t reg_rdata,
    input wire logic ring_indicator_first,
    input wire logic ring_indicator_second,
    input wire logic keyboard_wake,
    input wire logic mouse_wake,
    input wire logic specific_key_wake,
    input wire logic fan_speed_input_first,
    input wire logic fan_speed_input_second,
    input wire logic [7:0] gen_pins_10_17,
    input wire logic [2:0] gen_pins_20_22,
    input wire logic [3:0] gen_pins_24_27,
    input wire logic grouped_device_interrupt_status,
    input wire wes_pkg::wes_byte_t src_enable_misc,
    input wire wes_pkg::wes_byte_t src_enable_grp1,
    input wire wes_pkg::wes_byte_t src_enable_grp2,
    output logic wake_request_n
);
    import wes_pkg::*;

    // Write-one-to-clear update; a set arriving with the clear wins
    function automatic wes_byte_t w1c_next(input wes_byte_t cur, input wes_byte_t set,
                                           input wes_byte_t clr, input logic wr);
        wes_byte_t mask;
        mask = wr ? clr : 8'h00;
        w1c_next = (cur & ~mask) | set;
    endfunction

    logic global_wake_flag_bit_reg;
    logic wake_output_enable_bit_reg;
    wes_byte_t sts_misc_reg;
    wes_byte_t sts_grp1_reg;
    wes_byte_t sts_grp2_reg;
    wes_byte_t reg_rdata_reg;
    logic wake_request_n_reg;

    wire logic [21:0] pin_rise;
    wire logic devint_rise;

    // External pins are synchronised before edge detection
    wes_edge_detect #(
        .W(22),
        .SYNC(1'b1)
    ) u_pin_edges (
        .clk(clk),
        .rst_n(rst_n),
        .level_in({gen_pins_24_27, gen_pins_20_22, gen_pins_10_17,
                   fan_speed_input_second, fan_speed_input_first, specific_key_wake,
                   mouse_wake, keyboard_wake, ring_indicator_first, ring_indicator_second}),
        .rise_pulse(pin_rise)
    );

    // Grouped interrupt status is on-chip logic on this clock
    wes_edge_detect #(
        .W(1),
        .SYNC(1'b0)
    ) u_devint_edge (
        .clk(clk),
        .rst_n(rst_n),
        .level_in(grouped_device_interrupt_status),
        .rise_pulse(devint_rise)
    );

    // Event bytes laid out in status-bit order; bit 0 of the first is reserved
    wire wes_byte_t ev_misc = {pin_rise[6:0], 1'b0};
    wire wes_byte_t ev_grp1 = pin_rise[14:7];
    wire wes_byte_t ev_grp2 = {pin_rise[21:18], devint_rise, pin_rise[17:15]};

    // Register decode
    wire logic wr_flag = reg_wr && (reg_addr == `WES_OFS_FLAG);
    wire logic wr_enable = reg_wr && (reg_addr == `WES_OFS_ENABLE);
    wire logic wr_misc = reg_wr && (reg_addr == `WES_OFS_STS_MISC);
    wire logic wr_grp1 = reg_wr && (reg_addr == `WES_OFS_STS_GRP1);
    wire logic wr_grp2 = reg_wr && (reg_addr == `WES_OFS_STS_GRP2);

    // Enabled sources: a new enabled event raises the global flag
    wire logic enabled_event = |((ev_misc & src_enable_misc) | (ev_grp1 & src_enable_grp1)
                                  | (ev_grp2 & src_enable_grp2));
    // Any status bit still set with its own enable set
    wire logic enabled_pending = |((sts_misc_reg & src_enable_misc)
                                    | (sts_grp1_reg & src_enable_grp1)
                                    | (sts_grp2_reg & src_enable_grp2));

    // Status next values; the reserved bit never sets
    wire wes_byte_t sts_misc_next = w1c_next(sts_misc_reg, ev_misc, reg_wdata, wr_misc);
    wire wes_byte_t sts_grp1_next = w1c_next(sts_grp1_reg, ev_grp1, reg_wdata, wr_grp1);
    wire wes_byte_t sts_grp2_next = w1c_next(sts_grp2_reg, ev_grp2, reg_wdata, wr_grp2);

    // Flag sets regardless of the enable; write of one clears, set wins
    wire logic flag_next = (global_wake_flag_bit_reg
                            && !(wr_flag && reg_wdata[`WES_FLAG_BIT]))
                           || enabled_event;
    wire logic enable_next = wr_enable ? reg_wdata[`WES_ENABLE_BIT]
                                       : wake_output_enable_bit_reg;

    // Request asserted only with enable, flag and an enabled pending source
    wire logic drive_request = wake_output_enable_bit_reg && global_wake_flag_bit_reg
                               && enabled_pending;

    // Read mux; reserved offsets and bits read zero
    wire wes_byte_t rd_mux =
        (reg_addr == `WES_OFS_FLAG) ? {7'h00, global_wake_flag_bit_reg} :
        (reg_addr == `WES_OFS_ENABLE) ? {7'h00, wake_output_enable_bit_reg} :
        (reg_addr == `WES_OFS_STS_MISC) ? sts_misc_reg :
        (reg_addr == `WES_OFS_STS_GRP1) ? sts_grp1_reg :
        (reg_addr == `WES_OFS_STS_GRP2) ? sts_grp2_reg : 8'h00;

    // Only the standby-supply reset reaches these; other resets are not wired in
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            global_wake_flag_bit_reg <= 1'(`WES_RST_FLAG);
            wake_output_enable_bit_reg <= 1'(`WES_RST_ENABLE);
        end else begin
            global_wake_flag_bit_reg <= flag_next;
            wake_output_enable_bit_reg <= enable_next;
        end
    end

    // Per-source status, sticky until written with one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sts_misc_reg <= `WES_RST_STATUS;
            sts_grp1_reg <= `WES_RST_STATUS;
            sts_grp2_reg <= `WES_RST_STATUS;
        end else begin
            sts_misc_reg <= sts_misc_next;
            sts_grp1_reg <= sts_grp1_next;
            sts_grp2_reg <= sts_grp2_next;
        end
    end

    // Read data registered; held between reads so the host can sample late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_reg <= rd_mux;
        end
    end

    // Active-low request straight from a flop, no glitches on the pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_request_n_reg <= 1'b1;
        end else begin
            wake_request_n_reg <= !drive_request;
        end
    end

    assign reg_rdata = reg_rdata_reg;
    assign wake_request_n = wake_request_n_reg;

    // An enabled event always raises the flag next cycle
    flag_set_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        enabled_event |=> global_wake_flag_bit_reg)
        else $error("Global flag missed an enabled event");

    // Writing one clears the flag when no new event races it
    flag_clear_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_flag && reg_wdata[`WES_FLAG_BIT] && !enabled_event)
        |=> !global_wake_flag_bit_reg ##1 wake_request_n)
        else $error("Global flag or request not cleared by write of one");

    // Writing zero leaves a set flag alone
    flag_keep_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_flag && !reg_wdata[`WES_FLAG_BIT] && global_wake_flag_bit_reg)
        |=> global_wake_flag_bit_reg)
        else $error("Global flag lost on write of zero");

    // Reserved offsets read back zero
    rsvd_read_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && (reg_addr == `WES_OFS_RSVD_ONE || reg_addr == `WES_OFS_RSVD_THREE))
        |=> (reg_rdata == 8'h00))
        else $error("Reserved offset read nonzero");

    // With the global enable off the request stays released
    enable_gate_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !wake_output_enable_bit_reg |=> wake_request_n)
        else $error("Request driven while global enable off");

    // Keyboard event shows in status one bit 3 regardless of enables
    misc_status_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ev_misc[3] |=> sts_misc_reg[3])
        else $error("Keyboard status not set");

    // Reserved status bit never sets
    misc_rsvd_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !sts_misc_reg[`WES_MISC_RSVD_BIT])
        else $error("Reserved status bit set");

    // Pin 10 lands in status two bit 0, three flops after the pin rises
    pin_ten_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!gen_pins_10_17[0] ##1 gen_pins_10_17[0] [*3]) |=> sts_grp1_reg[0])
        else $error("Pin 10 status not set");

    // Grouped interrupt lands in status three bit 3
    devint_status_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        devint_rise |=> sts_grp2_reg[`WES_GRP2_DEVINT_BIT])
        else $error("Grouped interrupt status not set");

    // Status two write clears exactly the bits written one
    grp1_w1c_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_grp1 && ev_grp1 == 8'h00)
        |=> (sts_grp1_reg == ($past(sts_grp1_reg) & ~$past(reg_wdata))))
        else $error("Status two write-one-to-clear wrong");

    // All three gates open drives the request one cycle later
    request_drive_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wake_output_enable_bit_reg && global_wake_flag_bit_reg && enabled_pending)
        |=> !wake_request_n)
        else $error("Request not driven with all gates open");

    // Nothing enabled pending means no request, whatever the status holds
    disabled_source_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !enabled_pending |=> wake_request_n)
        else $error("Request driven by a disabled source");

    // Request held while the enabled condition stands
    request_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!wake_request_n && wake_output_enable_bit_reg && global_wake_flag_bit_reg
         && enabled_pending) |=> !wake_request_n)
        else $error("Request dropped while condition held");

    // Pin 24 lands in status three bit 4, above the grouped interrupt
    grp2_map_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!gen_pins_24_27[0] ##1 gen_pins_24_27[0] [*3]) |=> sts_grp2_reg[4])
        else $error("Pin 24 status not set");

    // Second ring indicator lands in status one bit 1
    ring_map_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!ring_indicator_second ##1 ring_indicator_second [*3]) |=> sts_misc_reg[1])
        else $error("Second ring status not set");

    // Second fan input lands in status one bit 7
    fan_map_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!fan_speed_input_second ##1 fan_speed_input_second [*3]) |=> sts_misc_reg[7])
        else $error("Second fan status not set");

    // Pin 17 lands in status two bit 7
    pin_seventeen_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!gen_pins_10_17[7] ##1 gen_pins_10_17[7] [*3]) |=> sts_grp1_reg[7])
        else $error("Pin 17 status not set");

    // Enable write takes bit 0 of the data
    enable_write_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_enable |=> (wake_output_enable_bit_reg == $past(reg_wdata[`WES_ENABLE_BIT])))
        else $error("Global enable write not taken");

    // Upper bits of flag and enable read zero
    rsvd_bits_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && (reg_addr == `WES_OFS_FLAG || reg_addr == `WES_OFS_ENABLE))
        |=> (reg_rdata[7:1] == 7'h00))
        else $error("Reserved upper bits read nonzero");

    // Status one moves only on an event or a write holding ones
    misc_stable_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ev_misc == 8'h00 && !(wr_misc && (reg_wdata != 8'h00))) |=> $stable(sts_misc_reg))
        else $error("Status one changed without event or clear");

    // Every event bit of status three is set next cycle, clear or not
    grp2_set_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ev_grp2 != 8'h00) |=> ((sts_grp2_reg & $past(ev_grp2)) == $past(ev_grp2)))
        else $error("Status three event lost");

    // Events of disabled sources never raise the global flag
    flag_quiet_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!global_wake_flag_bit_reg && !enabled_event) |=> !global_wake_flag_bit_reg)
        else $error("Global flag raised without an enabled event");
endmodule // wes_wake_status

`default_nettype wire

// File: pkg/wes_map.svh
`ifndef WES_MAP_SVH
`define WES_MAP_SVH

// Register offsets within the runtime block
`define WES_OFS_FLAG 8'h00
`define WES_OFS_RSVD_ONE 8'h01
`define WES_OFS_ENABLE 8'h02
`define WES_OFS_RSVD_THREE 8'h03
`define WES_OFS_STS_MISC 8'h04
`define WES_OFS_STS_GRP1 8'h05
`define WES_OFS_STS_GRP2 8'h06

// Reset values, applied on standby-supply power-on only
`define WES_RST_FLAG 8'h00
`define WES_RST_ENABLE 8'h00
`define WES_RST_STATUS 8'h00

// Field positions
`define WES_FLAG_BIT 0
`define WES_ENABLE_BIT 0
`define WES_MISC_RSVD_BIT 0
`define WES_GRP2_DEVINT_BIT 3

`endif

// File: pkg/wes_pkg.sv
`default_nettype none

package wes_pkg;
    // One runtime register byte
    typedef logic [7:0] wes_byte_t;
    // Offset within the runtime block
    typedef logic [7:0] wes_addr_t;
endpackage

`default_nettype wire
